// [inc/lacc_consts.svh]
`ifndef LACC_CONSTS_SVH
`define LACC_CONSTS_SVH

// operation-mode field codes
`define LACC_MODE_PD       3'h0
`define LACC_MODE_AMB      3'h5
`define LACC_MODE_IR       3'h6

// resolution select codes
`define LACC_RES_16        2'h0
`define LACC_RES_12        2'h1
`define LACC_RES_8         2'h2
`define LACC_RES_4         2'h3

// counter terminal values per resolution
`define LACC_MASK_16       16'hFFFF
`define LACC_MASK_12       16'h0FFF
`define LACC_MASK_8        16'h00FF
`define LACC_MASK_4        16'h000F

// result byte addresses as seen by the serial slave
`define LACC_ADDR_DATA_LO  8'h02
`define LACC_ADDR_DATA_HI  8'h03

// reset values
`define LACC_DATA_RST      16'h0000
`define LACC_RANGE_RST     2'h0
`define LACC_RES_RST       2'h0

`endif

// [inc/lacc_pkg.sv]
package lacc_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ST_PD  = 2'b00,
    ST_ARM = 2'b01,
    ST_INT = 2'b10
  } lacc_state_t;

endpackage

// [core/lacc_conv_ctrl.sv]
`timescale 1ns/1ps
`include "lacc_consts.svh"
module lacc_conv_ctrl
  import lacc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       osc_clk,
  input  wire logic       cb_pulse,
  input  wire logic       mode_wr,
  input  wire logic [2:0] mode_code,
  input  wire logic       one_shot_cmd,
  input  wire logic       one_shot_ir,
  input  wire logic       ext_cmd,
  input  wire logic       cfg_wr,
  input  wire logic       cfg_ext_timing,
  input  wire logic [1:0] cfg_range,
  input  wire logic [1:0] cfg_res,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  output logic      [7:0] data_lo,
  output logic      [7:0] data_hi,
  output logic      [1:0] range_out,
  output logic            sense_ir,
  output logic            integrating,
  output logic            power_down,
  output logic            data_new
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [2:0]  osc_sync_ff;
  logic [2:0]  cb_sync_ff;

  // stage 0 feeds only stage 1; edge seen between stages 1 and 2
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_sync_ff <= 3'h0;
      cb_sync_ff  <= 3'h0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], osc_clk};
      cb_sync_ff  <= {cb_sync_ff[1:0], cb_pulse};
    end
  end

  wire osc_rise = osc_sync_ff[1] & ~osc_sync_ff[2];
  wire cb_rise  = cb_sync_ff[1] & ~cb_sync_ff[2];

  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  logic        ext_ff;
  logic [1:0]  range_ff;
  logic [1:0]  res_ff;

  // range, resolution and timing select may change at any time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_ff   <= 1'b0;
      range_ff <= `LACC_RANGE_RST;
      res_ff   <= `LACC_RES_RST;
    end else if (cfg_wr) begin
      ext_ff   <= cfg_ext_timing;
      range_ff <= cfg_range;
      res_ff   <= cfg_res;
    end
  end

  // terminal count for the selected resolution
  wire [15:0] res_mask = (res_ff == `LACC_RES_4)  ? `LACC_MASK_4  :
                         (res_ff == `LACC_RES_8)  ? `LACC_MASK_8  :
                         (res_ff == `LACC_RES_12) ? `LACC_MASK_12 :
                                                    `LACC_MASK_16;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire code_pd   = (mode_code == `LACC_MODE_PD);
  wire code_amb  = (mode_code == `LACC_MODE_AMB);
  wire code_ir   = (mode_code == `LACC_MODE_IR);
  wire cmd_pd    = mode_wr & code_pd;
  wire cmd_cont  = mode_wr & (code_amb | code_ir);
  // reserved codes leave the sequencer and its counters alone
  wire mode_take = cmd_pd | cmd_cont;
  wire os_take   = one_shot_cmd & ~mode_take;
  wire cmd_start = cmd_cont | os_take;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  lacc_state_t state_ff;
  lacc_state_t nxt_state;
  logic        cont_ff;
  logic        ir_ff;
  logic [15:0] per_cnt_ff;
  logic [15:0] light_cnt_ff;
  logic [15:0] data_ff;

  wire in_int    = (state_ff == ST_INT);
  wire end_int   = ~ext_ff & osc_rise & (per_cnt_ff == res_mask);
  wire end_ext   = ext_ff & ext_cmd;
  wire conv_done = in_int & (end_int | end_ext) & ~mode_take & ~one_shot_cmd;
  wire ext_open  = (state_ff == ST_ARM) & ext_cmd & ~mode_take & ~one_shot_cmd;
  wire clr_cnt   = mode_take | one_shot_cmd | conv_done | ext_open;
  wire [15:0] result_val = ext_ff ? per_cnt_ff : light_cnt_ff;

  // next state: host commands take priority over conversion end
  always_comb begin
    nxt_state = state_ff;
    if (cmd_pd) begin
      nxt_state = ST_PD;
    end else if (cmd_start) begin
      nxt_state = ext_ff ? ST_ARM : ST_INT;
    end else begin
      unique case (state_ff)
        ST_PD:   nxt_state = ST_PD;
        ST_ARM:  nxt_state = ext_cmd ? ST_INT : ST_ARM;
        ST_INT:  nxt_state = (conv_done & ~cont_ff) ? ST_PD : ST_INT;
        default: nxt_state = ST_PD;
      endcase
    end
  end

  // state and measurement kind
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ST_PD;
      cont_ff  <= 1'b0;
      ir_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (cmd_cont) begin
        cont_ff <= 1'b1;
        ir_ff   <= code_ir;
      end else if (os_take) begin
        cont_ff <= 1'b0;
        ir_ff   <= one_shot_ir;
      end
    end
  end

  // period counter: oscillator edges, saturating at full 16 bits
  always_ff @(posedge core_clk) begin
    if (rst || clr_cnt) begin
      per_cnt_ff <= 16'h0000;
    end else if (in_int && osc_rise && per_cnt_ff != 16'hFFFF) begin
      per_cnt_ff <= per_cnt_ff + 16'h0001;
    end
  end

  // light counter: charge-balance packets, saturating at n-bit full scale
  always_ff @(posedge core_clk) begin
    if (rst || clr_cnt) begin
      light_cnt_ff <= 16'h0000;
    end else if (in_int && cb_rise && light_cnt_ff != res_mask) begin
      light_cnt_ff <= light_cnt_ff + 16'h0001;
    end
  end

  // result: one 16-bit register, both bytes change in the same edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_ff  <= `LACC_DATA_RST;
      data_new <= 1'b0;
    end else begin
      data_new <= conv_done;
      if (conv_done) begin
        data_ff <= result_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs and result byte read
  // ---------------------------------------------------------------
  assign data_lo     = data_ff[7:0];
  assign data_hi     = data_ff[15:8];
  assign range_out   = range_ff;
  assign sense_ir    = ir_ff;
  assign integrating = in_int;
  assign power_down  = (state_ff == ST_PD);
  assign rd_data     = (rd_addr == `LACC_ADDR_DATA_LO) ? data_ff[7:0]  :
                       (rd_addr == `LACC_ADDR_DATA_HI) ? data_ff[15:8] :
                                                         8'h00;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb_main @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_done_one;
    conv_done && !cont_ff;
  endsequence
  sequence s_done_cont;
    conv_done && cont_ff;
  endsequence

  a_reset_state: assert property (@(posedge core_clk) disable iff (1'b0)
    rst |=> power_down && data_ff == 16'h0000)
    else $error("reset did not give power-down with zero data");
  a_pd_command: assert property (cmd_pd |=> power_down && !integrating)
    else $error("power-down command not obeyed");
  a_oneshot_stop: assert property (s_done_one |=> power_down ##1 $stable(data_ff))
    else $error("one-shot did not stop with result kept");
  a_cont_rerun: assert property (s_done_cont |=> integrating)
    else $error("continuous conversion did not restart");
  a_data_whole: assert property (conv_done |=> data_ff == $past(result_val))
    else $error("result not loaded as one word");
  a_data_steady: assert property (!conv_done |=> $stable(data_ff))
    else $error("result changed without a conversion end");
  a_int_timing: assert property (in_int && !ext_ff && !mode_wr && !one_shot_cmd
    && osc_rise && per_cnt_ff == res_mask |-> conv_done)
    else $error("internal period did not end at terminal count");
  a_ext_timing: assert property ((state_ff == ST_ARM) && ext_cmd && !mode_wr
    && !one_shot_cmd |=> integrating && per_cnt_ff == 16'h0000)
    else $error("external command did not open a period");
  a_ext_result: assert property (conv_done && ext_ff |=> data_ff == $past(per_cnt_ff))
    else $error("external result is not the cycle count");
  a_mode_decode: assert property (mode_wr && mode_code == 3'h6 |=> sense_ir && cont_ff)
    else $error("infrared continuous code not decoded");
  a_resv_ignore: assert property (mode_wr && !mode_take && !one_shot_cmd && !conv_done
    && !ext_open |=> $stable(state_ff) && $stable(cont_ff) && $stable(ir_ff))
    else $error("reserved mode code changed the sequencer");
  a_range_set: assert property (cfg_wr |=> range_out == $past(cfg_range))
    else $error("range not updated");
  a_read_bytes: assert property (rd_addr == 8'h03 |-> rd_data == data_ff[15:8])
    else $error("high result byte read wrong");

endmodule // lacc_conv_ctrl

// [testbench/lacc_light_src.sv]
`timescale 1ns/1ps
// ----------------------------------------
// photodiode front end and oscillator model
// ----------------------------------------
module lacc_light_src (
  input  wire logic        osc_go,
  input  wire logic [15:0] osc_n,
  input  wire logic        cb_on,
  output logic             osc_clk,
  output logic             cb_pulse
);
  initial osc_clk = 1'b0;
  initial cb_pulse = 1'b0;
  // burst of exactly osc_n rises, still between bursts
  always @(posedge osc_go) repeat (osc_n) begin
    #200 osc_clk = 1'b1;
    #200 osc_clk = 1'b0;
  end
  // charge-balance packets while light falls on the diode
  always #150 cb_pulse = cb_on & ~cb_pulse;
endmodule // lacc_light_src

// [testbench/light_adc_conversion_control_tb.sv]
`timescale 1ns/1ps
`include "lacc_consts.svh"
module light_adc_conversion_control_tb;
  logic       core_clk, rst, osc_clk, cb_pulse, mode_wr, one_shot_cmd, one_shot_ir, ext_cmd;
  logic       cfg_wr, cfg_ext_timing, sense_ir, integrating, power_down, data_new, osc_go, cb_on;
  logic [2:0] mode_code;
  logic [1:0] cfg_range, cfg_res, range_out;
  logic [7:0] rd_addr, rd_data, data_lo, data_hi;
  logic [15:0] osc_n;
  int         errors = 0;
  int         checks_done = 0;

  lacc_conv_ctrl uut (.core_clk(core_clk), .rst(rst), .osc_clk(osc_clk), .cb_pulse(cb_pulse),
    .mode_wr(mode_wr), .mode_code(mode_code), .one_shot_cmd(one_shot_cmd),
    .one_shot_ir(one_shot_ir), .ext_cmd(ext_cmd), .cfg_wr(cfg_wr),
    .cfg_ext_timing(cfg_ext_timing), .cfg_range(cfg_range), .cfg_res(cfg_res),
    .rd_addr(rd_addr), .rd_data(rd_data), .data_lo(data_lo), .data_hi(data_hi),
    .range_out(range_out), .sense_ir(sense_ir), .integrating(integrating),
    .power_down(power_down), .data_new(data_new));
  lacc_light_src src (.osc_go(osc_go), .osc_n(osc_n), .cb_on(cb_on), .osc_clk(osc_clk),
    .cb_pulse(cb_pulse));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask
  task automatic mode(input logic [2:0] c);
    @(posedge core_clk) begin mode_wr <= 1'b1; mode_code <= c; end
    @(posedge core_clk) mode_wr <= 1'b0;
  endtask
  task automatic cfg(input logic e, input logic [1:0] r, input logic [1:0] s);
    @(posedge core_clk) begin cfg_wr <= 1'b1; cfg_ext_timing <= e; cfg_range <= r; cfg_res <= s; end
    @(posedge core_clk) cfg_wr <= 1'b0;
  endtask
  task automatic ext;
    @(posedge core_clk) ext_cmd <= 1'b1;
    @(posedge core_clk) ext_cmd <= 1'b0;
  endtask
  task automatic osc(input logic [15:0] n);
    @(posedge core_clk) begin osc_n <= n; osc_go <= 1'b1; end
    @(posedge core_clk) osc_go <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk) rd_addr <= a;
    settle();
    chk({8'h00, rd_data}, {8'h00, exp}, "rd_data");
  endtask
  task automatic wait_new;
    // step past the edge so a pulse launched there is seen
    #1;
    for (int i = 0; i < 3000 && data_new !== 1'b1; i++) settle();
    chk({15'h0000, data_new}, 16'h0001, "data_new");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({15'h0000, power_down}, 16'h0001, "power_down");
    chk({15'h0000, integrating | data_new}, 16'h0000, "busy");
    chk({data_hi, data_lo}, `LACC_DATA_RST, "data");
    rd(`LACC_ADDR_DATA_HI, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_internal;
    cfg(1'b0, 2'h0, `LACC_RES_4);
    cb_on <= 1'b1;
    mode(`LACC_MODE_AMB);
    osc(16'd40);
    wait_new();
    chk({data_hi, data_lo}, `LACC_MASK_4, "data");
    rd(`LACC_ADDR_DATA_LO, 8'h0F);
    rd(`LACC_ADDR_DATA_HI, 8'h00);
    chk({14'h0000, integrating, sense_ir}, 16'h0002, "ambient run");
    wait_new();
    mode(3'h7);
    settle();
    chk({15'h0000, integrating}, 16'h0001, "reserved code");
    mode(`LACC_MODE_IR);
    settle();
    chk({15'h0000, sense_ir}, 16'h0001, "sense_ir");
    mode(`LACC_MODE_PD);
    settle();
    chk({14'h0000, power_down, integrating}, 16'h0002, "stopped");
    cb_on <= 1'b0;
    repeat (200) @(posedge core_clk);
    $display("test internal done");
  endtask
  task automatic t_range;
    cfg(1'b0, 2'h3, `LACC_RES_16);
    settle();
    chk({14'h0000, range_out}, 16'h0003, "range_out");
    cfg(1'b0, 2'h0, `LACC_RES_16);
    settle();
    chk({14'h0000, range_out}, 16'h0000, "range_out");
    $display("test range done");
  endtask
  task automatic t_external;
    cfg(1'b1, 2'h0, `LACC_RES_16);
    @(posedge core_clk) begin one_shot_cmd <= 1'b1; one_shot_ir <= 1'b1; end
    @(posedge core_clk) one_shot_cmd <= 1'b0;
    settle();
    chk({14'h0000, power_down, integrating}, 16'h0000, "armed");
    ext();
    settle();
    chk({15'h0000, integrating}, 16'h0001, "integrating");
    osc(16'd7);
    repeat (80) @(posedge core_clk); // host-chosen period, scaled down
    ext();
    wait_new();
    chk({data_hi, data_lo}, 16'h0007, "osc count");
    settle();
    chk({14'h0000, power_down, sense_ir}, 16'h0003, "one shot end");
    ext();
    settle();
    chk({14'h0000, power_down, integrating}, 16'h0002, "ext refused");
    rd(`LACC_ADDR_DATA_LO, 8'h07);
    $display("test external done");
  endtask
  task automatic t_oneshot8;
    cfg(1'b0, 2'h1, `LACC_RES_8);
    cb_on <= 1'b1;
    @(posedge core_clk) begin one_shot_cmd <= 1'b1; one_shot_ir <= 1'b0; end
    @(posedge core_clk) one_shot_cmd <= 1'b0;
    osc(16'h0100);
    ext();
    settle();
    chk({14'h0000, power_down, integrating}, 16'h0001, "ext ignored");
    wait_new();
    chk({data_hi, data_lo}, `LACC_MASK_8, "data");
    settle();
    chk({14'h0000, power_down, sense_ir}, 16'h0002, "one shot end");
    cb_on <= 1'b0;
    $display("test one-shot done");
  endtask
  task automatic t_rerst;
    cfg(1'b0, 2'h2, `LACC_RES_4);
    mode(`LACC_MODE_AMB);
    @(posedge core_clk) rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    chk({14'h0000, power_down, integrating}, 16'h0002, "state after reset");
    chk({data_hi, data_lo}, `LACC_DATA_RST, "data after reset");
    chk({13'h0000, range_out, data_new}, 16'h0000, "config after reset");
    $display("test mid-run reset done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // clock, reset and main sequence
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {rst, mode_wr, one_shot_cmd, one_shot_ir, ext_cmd, cfg_wr, cfg_ext_timing} = 7'h41;
    {mode_code, cfg_range, cfg_res, rd_addr, osc_n, osc_go, cb_on} = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_internal();
    t_range();
    t_oneshot8();
    t_external();
    t_rerst();
    results();
  end
  // watchdog
  initial begin
    #2000000;
    errors++;
    results();
  end
endmodule // light_adc_conversion_control_tb
